// *** rtl/adc_scan_regs.vh ***
// Purpose: constants for the group scan trigger control block
// Assumes: one clock, plain-port configuration, no register bus
// Notes: figures below are the field widths and encodings shared by the files that include this one
// How it works
// - each converter unit owns separate configuration
// - scan mode field 01b selects group scan
// - double trigger bit plus 5-bit channel
// - trigger start enable gates all triggers
// - 6-bit group A trigger source select
// - 6-bit group C select, one code deselects
// - group C enable adds group C
// - per-group channel masks pick channels
// - priority bit enables group arbitration
// - restart bit resumes discontinued low group
// - continuous bit, with priority bit set, relaunches lowest group repeatedly
// - restart channel bit resumes unfinished channel
// - 3-bit select for dedicated sample-hold use
// - 8-bit sample-hold sampling time
// - without priority, triggers ignored during scan
// - higher trigger halts lower, starts immediately
`ifndef ADC_SCAN_REGS_VH
`define ADC_SCAN_REGS_VH
`define SCAN_MODE_GROUP   2'h1
`define NUM_CHAN          32
`define CHAN_W            5
`define TRIG_SEL_W        6
`define NUM_TRIG_SRC      64
`define TRIG_SEL_NONE     6'h3f
`define CONV_TIME_NS      1000
`define CLK_PERIOD_NS     4
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define GRP_A             2'h0
`define GRP_B             2'h1
`define GRP_C             2'h2
`define GRP_NONE          2'h3
`endif

// *** rtl/trig_select.v ***
// Purpose: picks one timer event line by a 6-bit selector
// Assumes: event lines already synchronous to clk, one-cycle pulses
// Notes: the deselection code yields no trigger
`include "adc_scan_regs.vh"
module trig_select (
    input  wire [`NUM_TRIG_SRC-1:0] events,
    input  wire [`TRIG_SEL_W-1:0]   sel,
    output wire                     trig
);
    // pick event, none code gives nothing
    assign trig = (sel == `TRIG_SEL_NONE) ? 1'b0 : events[sel];
endmodule // trig_select

// *** rtl/chan_pick.v ***
// Purpose: finds the lowest selected channel at or above a start point
// Assumes: pure combinational search over a 32-bit mask
// Notes: found is low when no channel remains
`include "adc_scan_regs.vh"
module chan_pick (
    input  wire [`NUM_CHAN-1:0] mask,
    input  wire [`CHAN_W-1:0]   from,
    output reg  [`CHAN_W-1:0]   chan,
    output reg                  found
);
    integer i;
    // downward loop leaves the lowest match
    always @* begin
        chan  = 5'h00;
        found = 1'b0;
        for (i = `NUM_CHAN - 1; i >= 0; i = i - 1) begin
            if (mask[i] && (i >= from)) begin
                chan  = i[`CHAN_W-1:0];
                found = 1'b1;
            end
        end
    end
endmodule // chan_pick

// *** rtl/adc_group_scan_trigger_control.v ***
// Purpose: group scan sequencing, trigger gating and priority control
// Assumes: one instance per converter unit; timer events are clk pulses
// Notes: conversion itself is outside; conv_done ends each channel
`include "adc_scan_regs.vh"
module adc_group_scan_trigger_control (
    input  wire                     clk,
    input  wire                     rst,
    input  wire [1:0]               scan_mode_sel,
    input  wire                     double_trig_en,
    input  wire [`CHAN_W-1:0]       double_trig_chan,
    input  wire                     trig_start_en,
    input  wire [`TRIG_SEL_W-1:0]   grp_a_trig_sel,
    input  wire [`TRIG_SEL_W-1:0]   grp_b_trig_sel,
    input  wire [`TRIG_SEL_W-1:0]   grp_c_trig_sel,
    input  wire                     grp_c_en,
    input  wire [`NUM_CHAN-1:0]     grp_a_chan_sel,
    input  wire [`NUM_CHAN-1:0]     grp_b_chan_sel,
    input  wire [`NUM_CHAN-1:0]     grp_c_chan_sel,
    input  wire                     prio_ctrl_en,
    input  wire                     low_prio_restart,
    input  wire                     low_prio_continuous,
    input  wire                     restart_chan_sel,
    input  wire [2:0]               sh_bypass_sel,
    input  wire [7:0]               sh_sample_time,
    input  wire [`NUM_TRIG_SRC-1:0] timer_events,
    input  wire                     async_trig,
    input  wire                     conv_done,
    output reg                      conv_start,
    output reg  [`CHAN_W-1:0]       conv_chan,
    output reg                      conv_use_sh,
    output reg  [7:0]               conv_sh_time,
    output reg                      scan_busy,
    output reg  [1:0]               active_grp,
    output reg                      scan_end,
    output reg  [1:0]               scan_end_grp,
    output reg                      double_second
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PICK = 2'h1;
    localparam ST_CONV = 2'h2;

    reg [1:0]         state_reg;
    reg [1:0]         grp_reg;
    reg [`CHAN_W-1:0] chan_reg;
    reg [2:0]         pend_reg;      // groups waiting after halt or queued while busy
    reg [`CHAN_W-1:0] resume_a_reg;
    reg [`CHAN_W-1:0] resume_b_reg;
    reg [`CHAN_W-1:0] resume_c_reg;
    reg               dbl_half_reg;
    reg               wrap_reg;      // last channel done, next pick ends the scan
    reg [2:0]         as_sync_reg;
    reg               as_seen_reg;

    wire trig_a_raw;
    wire trig_b_raw;
    wire trig_c_raw;
    wire as_edge;
    wire [2:0] trig;
    wire [`NUM_CHAN-1:0] cur_mask;
    wire [`CHAN_W-1:0]   pick_from;
    wire [`CHAN_W-1:0]   next_chan;
    wire                 next_found;
    wire                 grp_mode;
    wire [2:0]           start_set;

    // group index to priority rank, A highest
    function higher;
        input [1:0] g;
        input [1:0] cur;
        begin
            higher = (g < cur);
        end
    endfunction

    // lowest pending group, A first
    function [1:0] first_grp;
        input [2:0] req;
        begin
            if (req[0])
                first_grp = `GRP_A;
            else if (req[1])
                first_grp = `GRP_B;
            else if (req[2])
                first_grp = `GRP_C;
            else
                first_grp = `GRP_NONE;
        end
    endfunction

    trig_select u_sel_a (
        .events (timer_events),
        .sel    (grp_a_trig_sel),
        .trig   (trig_a_raw)
    );
    trig_select u_sel_b (
        .events (timer_events),
        .sel    (grp_b_trig_sel),
        .trig   (trig_b_raw)
    );
    // group C source, may be deselected
    trig_select u_sel_c (
        .events (timer_events),
        .sel    (grp_c_trig_sel),
        .trig   (trig_c_raw)
    );

    // async trigger pin, three flops, edge once stages 2 and 3 agree high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            as_sync_reg <= 3'h0;
            as_seen_reg <= 1'b0;
        end else begin
            as_sync_reg <= {as_sync_reg[1:0], async_trig};
            if (as_sync_reg[1] == as_sync_reg[2])
                as_seen_reg <= as_sync_reg[2];
        end
    end
    assign as_edge = (as_sync_reg[1] & as_sync_reg[2]) & ~as_seen_reg;

    // only group scan mode runs this sequencer
    assign grp_mode = (scan_mode_sel == `SCAN_MODE_GROUP);
    // gated triggers; async start goes to group A
    assign trig[0] = trig_start_en & grp_mode & (trig_a_raw | as_edge);
    assign trig[1] = trig_start_en & grp_mode & trig_b_raw;
    assign trig[2] = trig_start_en & grp_mode & grp_c_en & trig_c_raw;

    assign cur_mask = (grp_reg == `GRP_A) ? grp_a_chan_sel :
                      (grp_reg == `GRP_B) ? grp_b_chan_sel :
                      (grp_reg == `GRP_C) ? grp_c_chan_sel : 32'h0;
    assign pick_from = chan_reg;

    chan_pick u_pick (
        .mask  (cur_mask),
        .from  (pick_from),
        .chan  (next_chan),
        .found (next_found)
    );

    // triggers accepted for a fresh start while idle
    assign start_set = trig;

    // one instance per unit holds its own settings
    // scan sequencer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            grp_reg       <= `GRP_NONE;
            chan_reg      <= 5'h00;
            pend_reg      <= 3'h0;
            resume_a_reg  <= 5'h00;
            resume_b_reg  <= 5'h00;
            resume_c_reg  <= 5'h00;
            dbl_half_reg  <= 1'b0;
            wrap_reg      <= 1'b0;
            conv_start    <= 1'b0;
            conv_chan     <= 5'h00;
            conv_use_sh   <= 1'b0;
            conv_sh_time  <= 8'h00;
            scan_busy     <= 1'b0;
            active_grp    <= `GRP_NONE;
            scan_end      <= 1'b0;
            scan_end_grp  <= `GRP_NONE;
            double_second <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            scan_end   <= 1'b0;
            if (!grp_mode) begin
                state_reg <= ST_IDLE;
                pend_reg  <= 3'h0;
                scan_busy <= 1'b0;
                active_grp <= `GRP_NONE;
                wrap_reg  <= 1'b0;
            end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (grp_mode && ((start_set | pend_reg) != 3'h0)) begin
                        grp_reg  <= first_grp(start_set | pend_reg);
                        case (first_grp(start_set | pend_reg))
                            `GRP_A:  chan_reg <= (restart_chan_sel & pend_reg[0] &
                                                  ~start_set[0]) ? resume_a_reg : 5'h00;
                            `GRP_B:  chan_reg <= (restart_chan_sel & pend_reg[1] &
                                                  ~start_set[1]) ? resume_b_reg : 5'h00;
                            default: chan_reg <= (restart_chan_sel & pend_reg[2] &
                                                  ~start_set[2]) ? resume_c_reg : 5'h00;
                        endcase
                        pend_reg  <= (start_set | pend_reg) &
                                     ~(3'h1 << first_grp(start_set | pend_reg));
                        state_reg <= ST_PICK;
                        scan_busy <= 1'b1;
                        active_grp <= first_grp(start_set | pend_reg);
                    end
                end
                ST_PICK: begin
                    wrap_reg <= 1'b0;
                    if (next_found && !wrap_reg) begin
                        conv_start <= 1'b1;
                        // second trigger converts the double channel
                        conv_chan  <= (double_trig_en && dbl_half_reg &&
                                       grp_reg == `GRP_A) ? double_trig_chan : next_chan;
                        double_second <= double_trig_en & dbl_half_reg &
                                         (grp_reg == `GRP_A);
                        conv_use_sh  <= (next_chan < 5'h03) ? ~sh_bypass_sel[next_chan[1:0]]
                                                            : 1'b0;
                        conv_sh_time <= sh_sample_time;
                        chan_reg  <= next_chan;
                        state_reg <= ST_CONV;
                    end else begin
                        // scan complete
                        scan_end     <= 1'b1;
                        scan_end_grp <= grp_reg;
                        if (double_trig_en && grp_reg == `GRP_A)
                            dbl_half_reg <= ~dbl_half_reg;
                        // finished group has no stale resume point
                        case (grp_reg)
                            `GRP_A:  resume_a_reg <= 5'h00;
                            `GRP_B:  resume_b_reg <= 5'h00;
                            default: resume_c_reg <= 5'h00;
                        endcase
                        // relaunch lowest group with nothing else pending
                        if (low_prio_continuous && prio_ctrl_en && pend_reg == 3'h0)
                            pend_reg[grp_c_en ? `GRP_C : `GRP_B] <= 1'b1;
                        state_reg  <= ST_IDLE;
                        scan_busy  <= 1'b0;
                        active_grp <= `GRP_NONE;
                    end
                end
                ST_CONV: begin
                    if (prio_ctrl_en && (trig[0] && higher(`GRP_A, grp_reg) ||
                                         trig[1] && higher(`GRP_B, grp_reg))) begin
                        // halt lower scan, start higher now
                        grp_reg    <= trig[0] ? `GRP_A : `GRP_B;
                        active_grp <= trig[0] ? `GRP_A : `GRP_B;
                        chan_reg   <= 5'h00;
                        state_reg  <= ST_PICK;
                        if (low_prio_restart)
                            pend_reg <= (pend_reg | (3'h1 << grp_reg) |
                                        (trig & ~(3'h1 << grp_reg))) &
                                        ~(trig[0] ? 3'h1 : 3'h2);
                        case (grp_reg)
                            `GRP_B:  resume_b_reg <= chan_reg;
                            default: resume_c_reg <= chan_reg;
                        endcase
                    end else begin
                        // queue lower triggers when restart is set
                        if (prio_ctrl_en && low_prio_restart)
                            pend_reg <= pend_reg | (trig & ~(3'h1 << grp_reg));
                        // otherwise other triggers are dropped
                        // channel 31 or the double channel ends the scan
                        if (conv_done) begin
                            chan_reg  <= chan_reg + 5'h01;
                            wrap_reg  <= (chan_reg == 5'h1f) | double_second;
                            state_reg <= ST_PICK;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            end
        end
    end
endmodule // adc_group_scan_trigger_control

// *** sim/adc_scan_asserts.sv ***
// Purpose: port checks for group scan control
// Assumes: one clock, rst async high
// Notes: bound into every instance
`include "adc_scan_regs.vh"
module adc_scan_asserts (
    input wire                 clk,
    input wire                 rst,
    input wire [1:0]           scan_mode_sel,
    input wire                 trig_start_en,
    input wire                 grp_c_en,
    input wire                 prio_ctrl_en,
    input wire [`CHAN_W-1:0]   double_trig_chan,
    input wire [`NUM_CHAN-1:0] grp_a_chan_sel,
    input wire [2:0]           sh_bypass_sel,
    input wire [7:0]           sh_sample_time,
    input wire                 conv_start,
    input wire [`CHAN_W-1:0]   conv_chan,
    input wire                 conv_use_sh,
    input wire [7:0]           conv_sh_time,
    input wire                 scan_busy,
    input wire [1:0]           active_grp,
    input wire                 scan_end,
    input wire                 double_second
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [`CHAN_W-1:0] last_chan_reg;
    reg [1:0]         last_grp_reg;
    reg               seen_reg;
    // last start within the running scan
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_reg      <= 1'b0;
            last_chan_reg <= 5'h00;
            last_grp_reg  <= 2'h3;
        end else if (scan_end || !scan_busy) begin
            seen_reg <= 1'b0;
        end else if (conv_start) begin
            seen_reg      <= 1'b1;
            last_chan_reg <= conv_chan;
            last_grp_reg  <= active_grp;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_mode_gate: assert property (
        scan_mode_sel != `SCAN_MODE_GROUP && !scan_busy |=> !scan_busy)
        else $error("scan began outside group scan mode");
    a_trig_gate: assert property (
        !trig_start_en && !scan_busy |=> !scan_busy)
        else $error("scan began with triggers disabled");
    a_chan_ascend: assert property (
        conv_start && seen_reg && active_grp == last_grp_reg |-> conv_chan > last_chan_reg)
        else $error("channel order not ascending");
    a_double_chan: assert property (
        conv_start && double_second |-> conv_chan == double_trig_chan && active_grp == 2'h0)
        else $error("double conversion on wrong channel");
    a_sh_fields: assert property (
        conv_start |-> conv_use_sh == (conv_chan < 3 && !sh_bypass_sel[conv_chan[1:0]])
        && conv_sh_time == sh_sample_time)
        else $error("sample hold fields wrong");
    a_grp_c_gate: assert property (
        scan_busy && active_grp == `GRP_C |-> grp_c_en)
        else $error("group c ran while disabled");
    a_no_preempt: assert property (
        scan_busy && $past(scan_busy) && !prio_ctrl_en |-> $stable(active_grp))
        else $error("group changed without priority");
    a_chan_mask: assert property (
        conv_start && active_grp == `GRP_A && !double_second |-> grp_a_chan_sel[conv_chan])
        else $error("channel outside group a mask");
endmodule // adc_scan_asserts
bind adc_group_scan_trigger_control adc_scan_asserts u_chk (.*);

// *** sim/timer_model.sv ***
// Purpose: motor timer issuing conversion start events
// Assumes: triangle count 0..TOP..0, one count per clk
// Notes: event 0 compare a, 1 peak, 2 trough
module timer_model #(
    parameter [7:0] BUF_A = 8'h10,
    parameter [1:0] XFER  = 2'h1
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  req_en,
    output reg  [63:0] events
);
    timeunit 1ns;
    timeprecision 100ps;
    reg  [7:0] timer_count;
    reg  [7:0] start_cycle_a;
    reg        down_reg;
    wire       peak   = !down_reg && timer_count == 8'h20;
    wire       trough = down_reg && timer_count == 8'h00;
    // counter, buffer copy and event pulses
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_count   <= 8'h00;
            down_reg      <= 1'b0;
            start_cycle_a <= 8'h00;
            events        <= 64'h0;
        end else begin
            if ((peak && XFER[0]) || (trough && XFER[1]))
                start_cycle_a <= BUF_A;
            events[0] <= timer_count == start_cycle_a && (down_reg ? req_en[3] : req_en[0]);
            events[1] <= peak && req_en[1];
            events[2] <= trough && req_en[2];
            if (peak || trough)
                down_reg <= !down_reg;
            timer_count <= (down_reg && !trough) || peak ? timer_count - 8'h01
                                                          : timer_count + 8'h01;
        end
    end
endmodule // timer_model

// *** sim/test_adc_group_scan_trigger_control.sv ***
// Purpose: self-checking bench for group scan control
// Assumes: inputs change on the falling edge
// Notes: engine answers each start six cycles later
`include "adc_scan_regs.vh"
module test_adc_group_scan_trigger_control;
    timeunit 1ns;
    timeprecision 100ps;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  scan_mode_sel = 2'h1;
    reg         double_trig_en = 1'b0;
    reg  [4:0]  double_trig_chan = 5'h0e;
    reg         trig_start_en = 1'b1;
    reg  [5:0]  grp_a_trig_sel = 6'h05;
    reg  [5:0]  grp_b_trig_sel = 6'h06;
    reg  [5:0]  grp_c_trig_sel = 6'h07;
    reg         grp_c_en = 1'b0;
    reg  [31:0] grp_a_chan_sel = 32'h00000016;
    reg  [31:0] grp_b_chan_sel = 32'h00000800;
    reg  [31:0] grp_c_chan_sel = 32'h00000700;
    reg         prio_ctrl_en = 1'b0;
    reg         low_prio_restart = 1'b0;
    reg         low_prio_continuous = 1'b0;
    reg         restart_chan_sel = 1'b0;
    reg  [2:0]  sh_bypass_sel = 3'h2;
    reg  [7:0]  sh_sample_time = 8'h2a;
    reg         async_trig = 1'b0;
    reg         conv_done = 1'b0;
    reg  [63:0] soft_ev = 64'h0;
    reg  [3:0]  tm_en = 4'h0;
    reg  [2:0]  cnt = 3'h0;
    integer     n_errors = 0;
    integer     checks = 0;
    integer     cyc = 0;
    wire [63:0] tm_ev;
    wire [63:0] timer_events = tm_ev | soft_ev;
    wire        conv_start, conv_use_sh, scan_busy, scan_end, double_second;
    wire [4:0]  conv_chan;
    wire [7:0]  conv_sh_time;
    wire [1:0]  active_grp, scan_end_grp;
    adc_group_scan_trigger_control dut (.*);
    timer_model tmr (.clk(clk), .rst(rst), .req_en(tm_en), .events(tm_ev));
    // clock
    initial begin
        forever #2 clk = ~clk;
    end
    // engine: done pulse after each start
    always @(negedge clk) begin
        conv_done <= cnt == 3'h1;
        if (conv_start)
            cnt <= 3'h6;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    task close_out;
        begin
            $display("errors %0d checks %0d", n_errors, checks);
            if (n_errors == 0 && checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task fire(input [5:0] idx);
        begin
            @(negedge clk);
            soft_ev[idx] = 1'b1;
            @(negedge clk);
            soft_ev[idx] = 1'b0;
        end
    endtask
    task next_start(output [4:0] ch, output [1:0] g);
        integer i;
        begin
            ch = 5'h1f;
            g = 2'h3;
            for (i = 0; i < 200 && ch === 5'h1f; i = i + 1) begin
                @(posedge clk);
                #1;
                if (conv_start === 1'b1) begin
                    ch = conv_chan;
                    g = active_grp;
                end
            end
        end
    endtask
    task exp_start(input [4:0] ech, input [1:0] eg);
        reg [4:0] ch;
        reg [1:0] g;
        begin
            next_start(ch, g);
            check(ch, ech);
            check(g, eg);
        end
    endtask
    task wait_idle;
        integer i;
        begin
            for (i = 0; i < 400 && scan_busy !== 1'b0; i = i + 1)
                @(negedge clk);
        end
    endtask
    // a trigger during a scan is dropped
    task s_no_prio;
        begin
            fire(6'h05);
            exp_start(5'h01, `GRP_A);
            fire(6'h06);
            exp_start(5'h02, `GRP_A);
            exp_start(5'h04, `GRP_A);
            wait_idle;
            repeat (20) @(negedge clk);
            check(scan_busy, 1'b0);
        end
    endtask
    // mode and enable gating
    task s_gates;
        begin
            scan_mode_sel = 2'h0;
            fire(6'h05);
            repeat (8) @(negedge clk);
            check(scan_busy, 1'b0);
            scan_mode_sel = 2'h1;
            trig_start_en = 1'b0;
            fire(6'h05);
            repeat (8) @(negedge clk);
            check(scan_busy, 1'b0);
            trig_start_en = 1'b1;
            async_trig = 1'b1;
            exp_start(5'h01, `GRP_A);
            async_trig = 1'b0;
            wait_idle;
        end
    endtask
    // double trigger alternates
    task s_double;
        integer k, nd;
        reg [4:0] ch;
        reg [1:0] g;
        begin
            double_trig_en = 1'b1;
            nd = 0;
            for (k = 0; k < 2; k = k + 1) begin
                fire(6'h05);
                next_start(ch, g);
                nd = nd + double_second;
                wait_idle;
            end
            check(nd, 1);
            double_trig_en = 1'b0;
        end
    endtask
    // each timer event kind starts group a
    task s_timer;
        integer k;
        reg [4:0] ch;
        reg [1:0] g;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                grp_a_trig_sel = (k == 3) ? 6'h00 : k[5:0];
                tm_en = 4'h1 << k;
                next_start(ch, g);
                check(g, `GRP_A);
                @(negedge clk);
                tm_en = 4'h0;
                wait_idle;
            end
            grp_a_trig_sel = 6'h00;
            repeat (150) @(negedge clk);
            check(scan_busy, 1'b0);
            grp_a_trig_sel = 6'h05;
        end
    endtask
    // preempt, queue and resume
    task s_prio;
        begin
            prio_ctrl_en = 1'b1;
            low_prio_restart = 1'b1;
            restart_chan_sel = 1'b1;
            grp_c_en = 1'b1;
            fire(6'h07);
            exp_start(5'h08, `GRP_C);
            exp_start(5'h09, `GRP_C);
            fire(6'h05);
            exp_start(5'h01, `GRP_A);
            fire(6'h06);
            exp_start(5'h02, `GRP_A);
            exp_start(5'h04, `GRP_A);
            exp_start(5'h0b, `GRP_B);
            exp_start(5'h09, `GRP_C);
            exp_start(5'h0a, `GRP_C);
            wait_idle;
        end
    endtask
    // lowest group relaunches, no source
    task s_cont;
        integer i, nc;
        begin
            low_prio_continuous = 1'b1;
            grp_c_trig_sel = `TRIG_SEL_NONE;
            fire(6'h05);
            nc = 0;
            for (i = 0; i < 600; i = i + 1) begin
                @(negedge clk);
                if (scan_end === 1'b1 && scan_end_grp === `GRP_C)
                    nc = nc + 1;
            end
            check(nc > 1, 1'b1);
            low_prio_continuous = 1'b0;
            wait_idle;
            repeat (40) @(negedge clk);
            check(scan_busy, 1'b0);
        end
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        s_no_prio;
        s_gates;
        s_double;
        s_timer;
        s_prio;
        s_cont;
        close_out;
    end
endmodule // test_adc_group_scan_trigger_control
